// file: design/tdc_pkg.sv
// Constants, opcodes and carrier types of the opcode decoder.
// Assumes one 100 MHz clock and a synchronous active-high reset.
package tdc_pkg;

  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_READ_TEMP_PORT_TWO = 8'hC3;
  localparam logic [7:0] OP_READ_TEMP_PORT_THREE = 8'hC4;
  localparam logic [7:0] OP_READ_TEMP_PORT_FOUR = 8'hC5;
  localparam logic [7:0] OP_READ_FIRST_WAVE_WIDTH = 8'hD0;
  localparam logic [7:0] OP_READ_FIRST_STOP_WIDTH = 8'hD1;
  localparam logic [7:0] OP_READ_STATUS = 8'hD2;
  localparam logic [7:0] OP_READ_COMM_CHECK = 8'hD3;
  localparam logic [7:0] OP_READ_CALIBRATION = 8'hD4;
  localparam logic [7:0] OP_INIT_RESULTS = 8'h70;
  localparam logic [7:0] OP_SOFT_RESET = 8'h50;
  localparam logic [7:0] OP_BEGIN_SINGLE_FLIGHT_TIME = 8'h01;
  localparam logic [7:0] OP_BEGIN_DUAL_DIRECTION_FLIGHT = 8'h03;
  localparam logic [7:0] OP_BEGIN_TEMP_SINGLE = 8'h04;
  localparam logic [7:0] OP_BEGIN_TEMP_DUAL = 8'h05;

  // ----------------------------------------------------------------
  // Read lengths in bytes and reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] LEN_TEMP = 3'h4;
  localparam logic [2:0] LEN_WIDTH = 3'h4;
  localparam logic [2:0] LEN_STATUS = 3'h2;
  localparam logic [2:0] LEN_CAL = 3'h4;
  localparam logic [2:0] LEN_COMM = 3'h1;
  localparam logic [2:0] LEN_WORD = 3'h4;
  localparam logic [2:0] LEN_RST = 3'h0;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam logic [23:0] COMM_PAD = 24'h00_0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    RSEL_NONE = 4'h0,
    RSEL_TEMP_TWO = 4'h1,
    RSEL_TEMP_THREE = 4'h2,
    RSEL_TEMP_FOUR = 4'h3,
    RSEL_WAVE_WIDTH = 4'h4,
    RSEL_STOP_WIDTH = 4'h5,
    RSEL_STATUS = 4'h6,
    RSEL_COMM = 4'h7,
    RSEL_CAL = 4'h8
  } tdc_rsel_t;

  typedef enum logic [1:0] {
    SLOT_UP = 2'h0,
    SLOT_DOWN = 2'h1,
    SLOT_TEMP_A = 2'h2,
    SLOT_TEMP_B = 2'h3
  } tdc_slot_t;

  typedef enum logic [2:0] {
    MEAS_IDLE = 3'h0,
    MEAS_TOF_ONE = 3'h1,
    MEAS_TOF_UP = 3'h2,
    MEAS_TOF_DOWN = 3'h3,
    MEAS_TEMP_ONE = 3'h4,
    MEAS_TEMP_A = 3'h5,
    MEAS_TEMP_B = 3'h6
  } tdc_meas_t;

  typedef struct packed {
    logic valid;
    tdc_rsel_t sel;
    logic [2:0] nbytes;
  } tdc_rd_req_t;

  typedef struct packed {
    logic tof;
    logic temp;
    logic fixed_dir;
    logic dir_down;
  } tdc_start_t;

  typedef struct packed {
    logic valid;
    tdc_slot_t slot;
  } tdc_store_t;

endpackage : tdc_pkg

// file: design/tdc_byte_shifter.sv
// Byte shifter that returns a selected register, first byte highest.
// Assumes load, take and abort come from logic on the same clock.
`timescale 1ns/1ps
module tdc_byte_shifter
  import tdc_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic load_i,
  input wire logic [31:0] word_i,
  input wire logic [2:0] nbytes_i,
  input wire logic take_i,
  input wire logic abort_i,
  output logic [7:0] byte_o,
  output logic valid_o
);

  // ----------------------------------------------------------------
  // Shift state
  // ----------------------------------------------------------------
  logic [31:0] word_q;
  logic [31:0] word_d;
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic [5:0] align;

  always_comb begin
    word_d = word_q;
    cnt_d = cnt_q;
    // Left-align so the first byte to send sits in the top lane
    align = {3'(LEN_WORD - nbytes_i), 3'b000};
    if (abort_i) begin
      cnt_d = LEN_RST;
    end else if (load_i) begin
      word_d = word_i << align;
      cnt_d = nbytes_i;
    end else if (take_i && (cnt_q != LEN_RST)) begin
      word_d = {word_q[23:0], 8'h00};
      cnt_d = 3'(cnt_q - 3'h1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      word_q <= WORD_RST;
      cnt_q <= LEN_RST;
    end else begin
      word_q <= word_d;
      cnt_q <= cnt_d;
    end
  end

  assign byte_o = word_q[31:24];
  assign valid_o = (cnt_q != LEN_RST);

endmodule : tdc_byte_shifter

// file: design/tdc_opcode_decoder.sv
// Opcode decoder: read selects, register init/reset, measurement starts.
// Assumes the serial front end hands over whole opcode bytes and byte
// take strobes on this clock; register file and engines sit outside.
//
// What this block does
// - Opcode C3 returns the second port temperature result.
// - Opcode C4 returns the third port temperature result.
// - Opcode C5 returns the fourth port temperature result.
// - Opcode D0 returns the first wave pulse width result.
// - Opcode D1 returns the first stop pulse width result.
// - Opcode D3 returns low eight bits of configuration register zero.
// - Opcode 70 clears result and status registers, keeps configuration.
// - Opcode 50 resets every register, configuration included.
// - Opcode 01 starts one flight time measurement per configuration.
// - Opcode 03 measures up then down, storing each without host help.
// - Opcode 05 runs two temperature passes and stores both.
`timescale 1ns/1ps
module tdc_opcode_decoder
  import tdc_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic op_valid_i,
  input wire logic [7:0] op_byte_i,
  input wire logic [7:0] cfg0_low_i,
  input wire logic [31:0] rd_word_i,
  input wire logic byte_take_i,
  input wire logic tof_done_i,
  input wire logic temp_done_i,
  output tdc_rd_req_t rd_req_o,
  output logic [7:0] tx_byte_o,
  output logic tx_valid_o,
  output logic init_o,
  output logic sw_reset_o,
  output tdc_start_t start_o,
  output tdc_store_t store_o,
  output logic busy_o
);

  // ----------------------------------------------------------------
  // Opcode decode
  // ----------------------------------------------------------------
  tdc_rd_req_t rd_q, rd_d;
  logic init_q, init_d;
  logic swr_q, swr_d;
  logic known;
  logic go_tof_one, go_tof_dual, go_temp_one, go_temp_dual;

  always_comb begin
    rd_d = rd_q;
    rd_d.valid = 1'b0;
    init_d = 1'b0;
    swr_d = 1'b0;
    known = 1'b1;
    go_tof_one = 1'b0;
    go_tof_dual = 1'b0;
    go_temp_one = 1'b0;
    go_temp_dual = 1'b0;
    if (op_valid_i) begin
      case (op_byte_i)
        OP_READ_TEMP_PORT_TWO: rd_d = '{1'b1, RSEL_TEMP_TWO, LEN_TEMP};
        OP_READ_TEMP_PORT_THREE:
          rd_d = '{1'b1, RSEL_TEMP_THREE, LEN_TEMP};
        OP_READ_TEMP_PORT_FOUR:
          rd_d = '{1'b1, RSEL_TEMP_FOUR, LEN_TEMP};
        OP_READ_FIRST_WAVE_WIDTH:
          rd_d = '{1'b1, RSEL_WAVE_WIDTH, LEN_WIDTH};
        OP_READ_FIRST_STOP_WIDTH:
          rd_d = '{1'b1, RSEL_STOP_WIDTH, LEN_WIDTH};
        OP_READ_STATUS: rd_d = '{1'b1, RSEL_STATUS, LEN_STATUS};
        OP_READ_COMM_CHECK: rd_d = '{1'b1, RSEL_COMM, LEN_COMM};
        OP_READ_CALIBRATION: rd_d = '{1'b1, RSEL_CAL, LEN_CAL};
        OP_INIT_RESULTS: init_d = 1'b1;
        OP_SOFT_RESET: swr_d = 1'b1;
        OP_BEGIN_SINGLE_FLIGHT_TIME: go_tof_one = 1'b1;
        OP_BEGIN_DUAL_DIRECTION_FLIGHT: go_tof_dual = 1'b1;
        OP_BEGIN_TEMP_SINGLE: go_temp_one = 1'b1;
        OP_BEGIN_TEMP_DUAL: go_temp_dual = 1'b1;
        default: known = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rd_q <= '{1'b0, RSEL_NONE, LEN_RST};
      init_q <= 1'b0;
      swr_q <= 1'b0;
    end else begin
      rd_q <= rd_d;
      init_q <= init_d;
      swr_q <= swr_d;
    end
  end

  // ----------------------------------------------------------------
  // Measurement sequencer
  // ----------------------------------------------------------------
  tdc_meas_t state_q, state_d;
  tdc_start_t start_q, start_d;
  tdc_store_t store_q, store_d;

  always_comb begin
    state_d = state_q;
    start_d = '0;
    store_d = '{1'b0, SLOT_UP};
    // Soft reset and init both drop any sequence in flight
    if (swr_d || init_d) begin
      state_d = MEAS_IDLE;
    end else begin
      case (state_q)
        MEAS_IDLE: begin
          if (go_tof_one) begin
            start_d = '{1'b1, 1'b0, 1'b0, 1'b0};
            state_d = MEAS_TOF_ONE;
          end else if (go_tof_dual) begin
            start_d = '{1'b1, 1'b0, 1'b1, 1'b0};
            state_d = MEAS_TOF_UP;
          end else if (go_temp_one) begin
            start_d = '{1'b0, 1'b1, 1'b0, 1'b0};
            state_d = MEAS_TEMP_ONE;
          end else if (go_temp_dual) begin
            start_d = '{1'b0, 1'b1, 1'b0, 1'b0};
            state_d = MEAS_TEMP_A;
          end
        end
        MEAS_TOF_ONE: begin
          if (tof_done_i) begin
            store_d = '{1'b1, SLOT_UP};
            state_d = MEAS_IDLE;
          end
        end
        MEAS_TOF_UP: begin
          if (tof_done_i) begin
            store_d = '{1'b1, SLOT_UP};
            start_d = '{1'b1, 1'b0, 1'b1, 1'b1};
            state_d = MEAS_TOF_DOWN;
          end
        end
        MEAS_TOF_DOWN: begin
          if (tof_done_i) begin
            store_d = '{1'b1, SLOT_DOWN};
            state_d = MEAS_IDLE;
          end
        end
        MEAS_TEMP_ONE: begin
          if (temp_done_i) begin
            store_d = '{1'b1, SLOT_TEMP_A};
            state_d = MEAS_IDLE;
          end
        end
        MEAS_TEMP_A: begin
          if (temp_done_i) begin
            store_d = '{1'b1, SLOT_TEMP_A};
            start_d = '{1'b0, 1'b1, 1'b0, 1'b0};
            state_d = MEAS_TEMP_B;
          end
        end
        MEAS_TEMP_B: begin
          if (temp_done_i) begin
            store_d = '{1'b1, SLOT_TEMP_B};
            state_d = MEAS_IDLE;
          end
        end
        default: begin
          state_d = MEAS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_q <= MEAS_IDLE;
      start_q <= '0;
      store_q <= '{1'b0, SLOT_UP};
    end else begin
      state_q <= state_d;
      start_q <= start_d;
      store_q <= store_d;
    end
  end

  // ----------------------------------------------------------------
  // Read-back path
  // ----------------------------------------------------------------
  logic [31:0] word_mux;

  // The check register is served here, not by the register file
  assign word_mux = (rd_q.sel == RSEL_COMM) ?
                    {COMM_PAD, cfg0_low_i} : rd_word_i;

  // Host clocks the bytes out with byte_take_i
  tdc_byte_shifter i_tdc_byte_shifter (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .load_i(rd_q.valid),
    .word_i(word_mux),
    .nbytes_i(rd_q.nbytes),
    .take_i(byte_take_i),
    .abort_i(swr_q),
    .byte_o(tx_byte_o),
    .valid_o(tx_valid_o)
  );

  assign rd_req_o = rd_q;
  assign init_o = init_q;
  assign sw_reset_o = swr_q;
  assign start_o = start_q;
  assign store_o = store_q;
  assign busy_o = (state_q != MEAS_IDLE);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_temp_two;
    @(posedge clk_i) disable iff (srst_i)
    op_valid_i && op_byte_i == OP_READ_TEMP_PORT_TWO
    |=> rd_req_o.valid && rd_req_o.sel == RSEL_TEMP_TWO
        ##1 tx_valid_o;
  endproperty
  a_temp_two: assert property (p_temp_two)
    else $error("temp port two read not issued");

  property p_temp_three;
    @(posedge clk_i) disable iff (srst_i)
    op_valid_i && op_byte_i == OP_READ_TEMP_PORT_THREE
    |=> rd_req_o.valid && rd_req_o.sel == RSEL_TEMP_THREE;
  endproperty
  a_temp_three: assert property (p_temp_three)
    else $error("temp port three read not issued");

  property p_temp_four;
    @(posedge clk_i) disable iff (srst_i)
    op_valid_i && op_byte_i == OP_READ_TEMP_PORT_FOUR
    |=> rd_req_o.valid && rd_req_o.sel == RSEL_TEMP_FOUR
        && rd_req_o.nbytes == LEN_TEMP;
  endproperty
  a_temp_four: assert property (p_temp_four)
    else $error("temp port four read not issued");

  property p_wave_width;
    @(posedge clk_i) disable iff (srst_i)
    op_valid_i && op_byte_i == OP_READ_FIRST_WAVE_WIDTH
    |=> rd_req_o.valid && rd_req_o.sel == RSEL_WAVE_WIDTH;
  endproperty
  a_wave_width: assert property (p_wave_width)
    else $error("first wave width read not issued");

  property p_stop_width;
    @(posedge clk_i) disable iff (srst_i)
    op_valid_i && op_byte_i == OP_READ_FIRST_STOP_WIDTH
    |=> rd_req_o.valid && rd_req_o.sel == RSEL_STOP_WIDTH;
  endproperty
  a_stop_width: assert property (p_stop_width)
    else $error("first stop width read not issued");

  property p_comm;
    @(posedge clk_i) disable iff (srst_i)
    op_valid_i && op_byte_i == OP_READ_COMM_CHECK
    ##1 !op_valid_i && !byte_take_i
    |=> tx_valid_o && tx_byte_o == $past(cfg0_low_i);
  endproperty
  a_comm: assert property (p_comm)
    else $error("check byte differs from configuration low byte");

  property p_init;
    @(posedge clk_i) disable iff (srst_i)
    op_valid_i && op_byte_i == OP_INIT_RESULTS
    |=> init_o && !sw_reset_o && !busy_o;
  endproperty
  a_init: assert property (p_init)
    else $error("init pulse missing or reset pulsed");

  property p_soft_reset;
    @(posedge clk_i) disable iff (srst_i)
    op_valid_i && op_byte_i == OP_SOFT_RESET
    ##1 !(op_valid_i && op_byte_i == OP_SOFT_RESET)
    |-> sw_reset_o && !init_o ##1 !tx_valid_o && !sw_reset_o;
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("soft reset not pulsed once or readout kept");

  property p_single_tof;
    @(posedge clk_i) disable iff (srst_i)
    op_valid_i && op_byte_i == OP_BEGIN_SINGLE_FLIGHT_TIME && !busy_o
    |=> start_o.tof && !start_o.fixed_dir && busy_o;
  endproperty
  a_single_tof: assert property (p_single_tof)
    else $error("single flight start wrong");

  property p_dual_turn;
    @(posedge clk_i) disable iff (srst_i)
    state_q == MEAS_TOF_UP && tof_done_i && !op_valid_i
    |=> store_o.valid && store_o.slot == SLOT_UP
        && start_o.tof && start_o.dir_down;
  endproperty
  a_dual_turn: assert property (p_dual_turn)
    else $error("down pass not launched after up pass");

  property p_temp_turn;
    @(posedge clk_i) disable iff (srst_i)
    state_q == MEAS_TEMP_A && temp_done_i && !op_valid_i
    |=> store_o.valid && store_o.slot == SLOT_TEMP_A && start_o.temp;
  endproperty
  a_temp_turn: assert property (p_temp_turn)
    else $error("second temperature pass not launched");

  property p_unknown;
    @(posedge clk_i) disable iff (srst_i)
    op_valid_i && !known && !tof_done_i && !temp_done_i
    |=> !rd_req_o.valid && !init_o && !sw_reset_o
        && start_o == '0 && $stable(state_q);
  endproperty
  a_unknown: assert property (p_unknown)
    else $error("unknown opcode had an effect");

  c_dual: cover property (@(posedge clk_i) disable iff (srst_i)
    state_q == MEAS_TOF_DOWN && tof_done_i);
  c_temp_dual: cover property (@(posedge clk_i) disable iff (srst_i)
    state_q == MEAS_TEMP_B && temp_done_i);
  c_read_out: cover property (@(posedge clk_i) disable iff (srst_i)
    tx_valid_o ##1 !tx_valid_o);
  c_abort: cover property (@(posedge clk_i) disable iff (srst_i)
    busy_o ##1 sw_reset_o && !busy_o);

endmodule : tdc_opcode_decoder

// file: testbench/tdc_host_model.sv
// Host side model: sends opcode bytes and clocks out read bytes.
// Assumes one clock shared with the decoder; drives on falling edges.
`timescale 1ns/1ps
module tdc_host_model (
  input wire logic clk_i,
  input wire logic [7:0] tx_byte_i,
  input wire logic tx_valid_i,
  output logic op_valid_o,
  output logic [7:0] op_byte_o,
  output logic byte_take_o
);
  initial begin
    op_valid_o = 1'b0;
    op_byte_o = 8'hA5;
    byte_take_o = 1'b0;
  end

  // ----------------------------------------------------------------
  // Opcode transfer
  // ----------------------------------------------------------------
  // Idle byte lane shows the inverse of the last opcode, not a stale copy
  task automatic send_op(input logic [7:0] op);
    @(negedge clk_i);
    op_valid_o = 1'b1;
    op_byte_o = op;
    @(negedge clk_i);
    op_valid_o = 1'b0;
    op_byte_o = ~op;
  endtask : send_op

  // ----------------------------------------------------------------
  // Read-out, gap gives a slow host between byte takes
  // ----------------------------------------------------------------
  task automatic read_bytes(input int n, input int gap,
                            output logic [31:0] w);
    int k;
    w = 32'h0000_0000;
    for (int i = 0; i < n; i++) begin
      k = 0;
      while (tx_valid_i !== 1'b1 && k < 20) begin
        @(negedge clk_i);
        k++;
      end
      w = {w[23:0], tx_byte_i};
      byte_take_o = 1'b1;
      @(negedge clk_i);
      if (gap > 0 || i == n - 1) begin
        byte_take_o = 1'b0;
        repeat (gap) @(negedge clk_i);
      end
    end
  endtask : read_bytes
endmodule : tdc_host_model

// file: testbench/tb_top.sv
// Self-checking bench of the opcode decoder with a host model.
// Assumes the decoder answers one cycle after each taken opcode.
`timescale 1ns/1ps
module tb_top
  import tdc_pkg::*;
;
  logic clk_i, srst_i, op_valid, take, tof_done, temp_done;
  logic [7:0] op_byte, cfg0_low, tx_byte;
  logic [31:0] rd_word;
  logic tx_valid, init, sw_reset, busy;
  tdc_rd_req_t rd_req;
  tdc_start_t start;
  tdc_store_t store;
  int fail_count, comparisons, cycles;

  function automatic logic [31:0] word_of(input tdc_rsel_t s);
    return {4'hA, s, 8'h5B, 8'hC7, 4'h1, s};
  endfunction : word_of

  assign rd_word = word_of(rd_req.sel);

  tdc_opcode_decoder i_tdc_opcode_decoder (
    .clk_i(clk_i), .srst_i(srst_i), .op_valid_i(op_valid),
    .op_byte_i(op_byte), .cfg0_low_i(cfg0_low), .rd_word_i(rd_word),
    .byte_take_i(take), .tof_done_i(tof_done),
    .temp_done_i(temp_done), .rd_req_o(rd_req), .tx_byte_o(tx_byte),
    .tx_valid_o(tx_valid), .init_o(init), .sw_reset_o(sw_reset),
    .start_o(start), .store_o(store), .busy_o(busy)
  );

  tdc_host_model i_tdc_host_model (
    .clk_i(clk_i), .tx_byte_i(tx_byte), .tx_valid_i(tx_valid),
    .op_valid_o(op_valid), .op_byte_o(op_byte), .byte_take_o(take)
  );

  // ----------------------------------------------------------------
  // Clock, timeout and reporting
  // ----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic end_of_test();
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic send(input logic [7:0] op);
    i_tdc_host_model.send_op(op);
  endtask : send

  // Engine done pulse; returns where the store pulse is visible
  task automatic pulse_done(input bit tof);
    @(negedge clk_i);
    tof_done = tof;
    temp_done = !tof;
    @(negedge clk_i);
    tof_done = 1'b0;
    temp_done = 1'b0;
  endtask : pulse_done

  task automatic idle_busy();
    repeat (2) @(negedge clk_i);
    chk({31'h0, busy}, 32'h0);
  endtask : idle_busy

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_read(input logic [7:0] op, input tdc_rsel_t sel,
                        input logic [2:0] nb, input int gap);
    logic [31:0] w, exp;
    exp = (sel == RSEL_COMM) ? {COMM_PAD, cfg0_low} : word_of(sel);
    // Only the low nb bytes of the register go out
    for (int i = int'(nb); i < 4; i++) exp[8*i +: 8] = 8'h00;
    send(op);
    chk({24'h0, rd_req}, {24'h0, 1'b1, sel, nb});
    i_tdc_host_model.read_bytes(int'(nb), gap, w);
    chk(w, exp);
    chk({31'h0, tx_valid}, 32'h0);
    $display("read test %h done", op);
  endtask : t_read

  task automatic t_single();
    send(OP_BEGIN_SINGLE_FLIGHT_TIME);
    chk({27'h0, start, busy}, {27'h0, 4'b1000, 1'b1});
    pulse_done(1'b0);
    chk({29'h0, store}, 32'h0);
    pulse_done(1'b1);
    chk({29'h0, store}, {29'h0, 1'b1, SLOT_UP});
    idle_busy();
    $display("single flight test done");
  endtask : t_single

  task automatic t_dual();
    send(OP_BEGIN_DUAL_DIRECTION_FLIGHT);
    chk({27'h0, start, busy}, {27'h0, 4'b1010, 1'b1});
    send(8'h02);
    chk({27'h0, start, busy}, {27'h0, 4'h0, 1'b1});
    pulse_done(1'b1);
    chk({25'h0, store, start}, {25'h0, 1'b1, SLOT_UP, 4'b1011});
    pulse_done(1'b1);
    chk({25'h0, store, start}, {25'h0, 1'b1, SLOT_DOWN, 4'h0});
    idle_busy();
    $display("dual flight test done");
  endtask : t_dual

  task automatic t_temp();
    send(OP_BEGIN_TEMP_DUAL);
    chk({30'h0, start.tof, start.temp}, 32'h1);
    send(OP_BEGIN_SINGLE_FLIGHT_TIME);
    chk({28'h0, start}, 32'h0);
    pulse_done(1'b0);
    chk({29'h0, store}, {29'h0, 1'b1, SLOT_TEMP_A});
    chk({31'h0, start.temp}, 32'h1);
    pulse_done(1'b0);
    chk({29'h0, store}, {29'h0, 1'b1, SLOT_TEMP_B});
    idle_busy();
    $display("temperature test done");
  endtask : t_temp

  task automatic t_temp_one();
    send(OP_BEGIN_TEMP_SINGLE);
    chk({27'h0, start, busy}, {27'h0, 4'b0100, 1'b1});
    pulse_done(1'b1);
    chk({29'h0, store}, 32'h0);
    pulse_done(1'b0);
    chk({29'h0, store}, {29'h0, 1'b1, SLOT_TEMP_A});
    idle_busy();
    $display("single temperature test done");
  endtask : t_temp_one

  task automatic t_init();
    send(OP_BEGIN_TEMP_DUAL);
    send(OP_INIT_RESULTS);
    chk({26'h0, init, sw_reset, start}, {26'h0, 2'b10, 4'h0});
    pulse_done(1'b0);
    chk({29'h0, store}, 32'h0);
    idle_busy();
    $display("init test done");
  endtask : t_init

  task automatic t_soft();
    send(OP_BEGIN_DUAL_DIRECTION_FLIGHT);
    send(OP_READ_TEMP_PORT_TWO);
    @(negedge clk_i);
    chk({31'h0, tx_valid}, 32'h1);
    send(OP_SOFT_RESET);
    chk({30'h0, init, sw_reset}, 32'h1);
    @(negedge clk_i);
    chk({31'h0, tx_valid}, 32'h0);
    idle_busy();
    $display("soft reset test done");
  endtask : t_soft

  task automatic t_unknown();
    logic [7:0] bad [4] = '{8'h00, 8'hFF, 8'h02, 8'hD5};
    tdc_rd_req_t prev;
    foreach (bad[i]) begin
      prev = rd_req;
      send(bad[i]);
      chk({17'h0, rd_req, start, init, sw_reset, tx_valid},
          {17'h0, 1'b0, prev[6:0], 7'h0});
      @(negedge clk_i);
      chk({30'h0, tx_valid, busy}, 32'h0);
    end
    $display("unknown opcode test done");
  endtask : t_unknown

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    srst_i = 1'b1;
    cfg0_low = 8'h96;
    tof_done = 1'b0;
    temp_done = 1'b0;
    fail_count = 0;
    comparisons = 0;
    cycles = 0;
    repeat (8) @(negedge clk_i);
    srst_i = 1'b0;
    chk({13'h0, rd_req, start, store, tx_valid, init, sw_reset, busy},
        32'h0);
    t_read(OP_READ_TEMP_PORT_TWO, RSEL_TEMP_TWO, LEN_TEMP, 0);
    t_read(OP_READ_TEMP_PORT_THREE, RSEL_TEMP_THREE, LEN_TEMP, 1);
    t_read(OP_READ_TEMP_PORT_FOUR, RSEL_TEMP_FOUR, LEN_TEMP, 2);
    t_read(OP_READ_FIRST_WAVE_WIDTH, RSEL_WAVE_WIDTH, LEN_WIDTH, 0);
    t_read(OP_READ_FIRST_STOP_WIDTH, RSEL_STOP_WIDTH, LEN_WIDTH, 0);
    cfg0_low = 8'h69;
    t_read(OP_READ_COMM_CHECK, RSEL_COMM, LEN_COMM, 1);
    t_read(OP_READ_STATUS, RSEL_STATUS, LEN_STATUS, 0);
    t_read(OP_READ_CALIBRATION, RSEL_CAL, LEN_CAL, 1);
    t_single();
    t_dual();
    t_temp();
    t_temp_one();
    t_init();
    t_soft();
    t_unknown();
    end_of_test();
  end
endmodule : tb_top
